// file: bench/rtc_radio_model.sv
`timescale 1ns/10ps
// ==========================================================
// radio side: mode settings and a clock tick on request
module rtc_radio_model #(
  parameter logic [31:0] TICK_VALUE = 32'h0000_1234
) (
  input wire logic clock,
  input wire logic tick_req,
  output logic rtc_tick,
  output logic [31:0] rtc_value,
  output logic [5:0] sync_len_cfg,
  output logic mode_whiten_en,
  output logic [31:0] mode_whiten_init
);
  int wait_cnt = 0;
  initial rtc_tick = 1'b0;
  // radio set up and synth running in tx mode before any tx test
  assign sync_len_cfg = 6'h18;
  assign mode_whiten_en = 1'b0;
  assign mode_whiten_init = 32'h0000_0000;
  // value held steady around the tick so the capture cannot tear
  assign rtc_value = TICK_VALUE;
  always @(posedge clock) begin
    wait_cnt <= tick_req ? wait_cnt + 1 : 0;
    rtc_tick <= tick_req && wait_cnt > 20 && wait_cnt < 40;
  end
endmodule

// file: bench/tb_radio_test_and_timer_stop_cmds.sv
`timescale 1ns/10ps
module tb_radio_test_and_timer_stop_cmds;
  import rtc_pkg::*;
  localparam logic [31:0] TICK_VALUE = 32'h0000_1234;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, tick_req = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] hrdata, rtc_value, mode_whiten_init, rx_sync_pattern;
  logic [5:0] sync_len_cfg;
  logic hreadyout, hresp, rtc_tick, mode_whiten_en, rx_en, sync_thresh_max;
  logic tx_en, tx_carrier_only, tx_data, tx_bit_strobe, synth_stop, irq;
  int bad_count = 0, total_checks = 0, cyc = 0, last_strobe = 0, gap_err = 0, stops = 0;
  logic q[$];
  rtc_core dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rtc_tick(rtc_tick), .rtc_value(rtc_value),
    .sync_len_cfg(sync_len_cfg), .mode_whiten_en(mode_whiten_en),
    .mode_whiten_init(mode_whiten_init), .rx_en(rx_en), .rx_sync_pattern(rx_sync_pattern),
    .sync_thresh_max(sync_thresh_max), .tx_en(tx_en), .tx_carrier_only(tx_carrier_only),
    .tx_data(tx_data), .tx_bit_strobe(tx_bit_strobe), .synth_stop(synth_stop), .irq(irq));
  rtc_radio_model #(.TICK_VALUE(TICK_VALUE)) radio_u (.clock(clock), .tick_req(tick_req),
    .rtc_tick(rtc_tick), .rtc_value(rtc_value), .sync_len_cfg(sync_len_cfg),
    .mode_whiten_en(mode_whiten_en), .mode_whiten_init(mode_whiten_init));
  always #50 clock = ~clock;
  // ==========================================================
  // monitors: bit capture, bit spacing, synth stop pulses, hang guard
  always @(posedge clock) begin
    cyc++;
    if (tx_bit_strobe === 1'b1) begin
      q.push_back(tx_data);
      if (last_strobe != 0 && cyc - last_strobe != 10) gap_err++;
      last_strobe = cyc;
    end
    if (synth_stop === 1'b1) stops++;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // bus master: single word transfers, waits on the slave's ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_unknown();
    wr(RTC_OFS_IRQ_MASK, 32'h0);
    wr(RTC_OFS_CMD, 32'h0000_0123);
    settle(4);
    chk(irq, 1'b0);
    rdc(RTC_OFS_STATUS, 32'h0001_0800);
    wr(RTC_OFS_IRQ_MASK, 32'h7);
    settle(2);
    chk(irq, 1'b1);
    rdc(RTC_OFS_IRQ_STAT, 32'h4);
    settle(2);
    chk(irq, 1'b0);
    rdc(8'h40, 32'h0);
  endtask
  task automatic t_rx_abort();
    int s0;
    wr(RTC_OFS_CFG, 32'h6);
    wr(RTC_OFS_SYNC, 32'h1234_5678);
    wr(RTC_OFS_TRIG, 32'h0);
    s0 = stops;
    wr(RTC_OFS_CMD, {16'h0000, RTC_ID_RX_TEST});
    settle(1);
    chk(rx_en, 1'b1);
    chk(rx_sync_pattern, 32'h1234_5678);
    chk(sync_thresh_max, 1'b1);
    rdc(RTC_OFS_STATUS, 32'h0002_0001);
    // a running test ignores a new sync pattern and a new test command
    wr(RTC_OFS_SYNC, 32'hFFFF_0000);
    wr(RTC_OFS_CMD, {16'h0000, RTC_ID_TX_TEST});
    settle(200);
    chk(rx_sync_pattern, 32'h1234_5678);
    chk({tx_en, rx_en}, 2'h1);
    wr(RTC_OFS_ABORT, 32'h1);
    settle(6);
    chk(rx_en, 1'b0);
    chk(sync_thresh_max, 1'b0);
    chk(stops - s0, 1);
    chk(irq, 1'b1);
    rdc(RTC_OFS_STATUS, 32'h0001_0401);
    rdc(RTC_OFS_IRQ_STAT, 32'h3);
  endtask
  task automatic t_rx_time();
    logic [31:0] t;
    int s0, n;
    wr(RTC_OFS_CFG, 32'h0);
    wr(RTC_OFS_TRIG, {24'h000000, RTC_TRIG_AT_TIME});
    bus(1'b0, RTC_OFS_TIMER, 32'h0, t);
    wr(RTC_OFS_ENDT, t + 32'd200);
    s0 = stops;
    wr(RTC_OFS_CMD, {16'h0000, RTC_ID_RX_TEST});
    // the command edge has not yet raised rx_en when the write returns
    settle(1);
    n = 0;
    while (rx_en !== 1'b0 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    settle(5);
    chk(n > 170 && n <= 200, 1'b1);
    chk(stops - s0, 0);
    rdc(RTC_OFS_STATUS, 32'h0001_0400);
    rdc(RTC_OFS_IRQ_STAT, 32'h1);
  endtask
  task automatic t_tx(input logic [3:0] cfg);
    logic [55:0] hdr;
    logic [7:0] head;
    logic [15:0] tw;
    logic w[$];
    int s0, n, err, ones;
    wr(RTC_OFS_CFG, {28'h0, cfg});
    wr(RTC_OFS_TRIG, 32'h0);
    wr(RTC_OFS_SYNC, 32'h00C3_5A96);
    wr(RTC_OFS_TRANSMIT_WORD, 32'h0000_B4E1);
    q.delete();
    last_strobe = 0;
    gap_err = 0;
    s0 = stops;
    wr(RTC_OFS_CMD, {16'h0000, RTC_ID_TX_TEST});
    settle(1);
    chk(tx_en, 1'b1);
    chk(tx_carrier_only, cfg[0]);
    n = 0;
    while (q.size() < 120 && n < (cfg[0] ? 300 : 1500)) begin
      @(posedge clock);
      n++;
    end
    if (cfg[0]) chk(q.size(), 0);
    else begin
      for (int i = 0; i < 56; i++) hdr = {hdr[54:0], q[i]};
      chk(hdr[55:24], 32'hAAAA_AAAA);
      chk(hdr[23:0], 24'hC35A96);
      err = 0;
      ones = 0;
      tw = 16'hB4E1;
      for (int i = 0; i < 64; i++) begin
        w.push_back(q[56 + i] ^ tw[15 - i % 16]);
        ones += w[i];
        if (i < 8) head = {head[6:0], w[i]};
        if (cfg[3:2] == 2'h2 && i >= 15 && w[i] !== (w[i - 15] ^ w[i - 14])) err++;
        if (cfg[3:2] == 2'h3 && i >= 32 && w[i] !== (w[i - 32] ^ w[i - 22] ^ w[i - 2] ^ w[i - 1]))
          err++;
        if (!cfg[3] && w[i] !== 1'b0) err++;
      end
      chk(err, 0);
      chk(ones != 0, cfg[3]);
      // first feedback bits that the 0xAAAA0000 seed yields in each generator
      if (cfg[3]) chk(head, cfg[2] ? 8'h03 : 8'hFF);
      chk(gap_err, 0);
    end
    wr(RTC_OFS_ABORT, 32'h1);
    settle(6);
    chk(tx_en, 1'b0);
    chk(stops - s0, cfg[1]);
    rdc(RTC_OFS_STATUS, 32'h0001_0401);
    rdc(RTC_OFS_IRQ_STAT, 32'h3);
  endtask
  task automatic t_tstop();
    logic [31:0] r, t1, t2;
    int n;
    wr(RTC_OFS_CMD, {16'h0000, RTC_ID_TSTOP});
    rdc(RTC_OFS_STATUS, 32'h0008_0001);
    tick_req <= 1'b1;
    n = 0;
    r = 32'h0;
    while (r[20:16] != 5'h01 && n < 30) begin
      bus(1'b0, RTC_OFS_STATUS, 32'h0, r);
      n++;
    end
    tick_req <= 1'b0;
    chk(n > 5, 1'b1);
    chk(r, 32'h0001_0400);
    bus(1'b0, RTC_OFS_TIMER, 32'h0, t1);
    settle(5);
    bus(1'b0, RTC_OFS_TIMER, 32'h0, t2);
    chk(t2, t1);
    // the timer still takes one step on the edge that stops it
    rdc(RTC_OFS_RESULT, t1 - TICK_VALUE - 32'h1);
    rdc(RTC_OFS_IRQ_STAT, 32'h1);
  endtask
  // ==========================================================
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rdc(RTC_OFS_STATUS, 32'h0001_0000);
    chk({irq, hresp}, 2'h0);
    t_unknown();
    t_rx_abort();
    t_rx_time();
    t_tx(4'h0);
    t_tx(4'h6);
    t_tx(4'h8);
    t_tx(4'hC);
    t_tx(4'h1);
    // timer stop last: the timer stays stopped afterwards
    t_tstop();
    give_verdict();
  end
endmodule

// file: core/rtc_core.sv
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module rtc_core
  import rtc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rtc_tick,
  input wire logic [31:0] rtc_value,
  input wire logic [5:0] sync_len_cfg,
  input wire logic mode_whiten_en,
  input wire logic [31:0] mode_whiten_init,
  output logic rx_en,
  output logic [31:0] rx_sync_pattern,
  output logic sync_thresh_max,
  output logic tx_en,
  output logic tx_carrier_only,
  output logic tx_data,
  output logic tx_bit_strobe,
  output logic synth_stop,
  output logic irq
);
  // ==========================================================
  // reset release
  logic rst_a_ff, rst_b_ff, rst_ok_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  assign rst_ok_n = rst_b_ff;

  // ==========================================================
  // registers and state
  rtc_state_type state_ff;
  rtc_phase_type phase_ff;
  logic [7:0] cfg_ff, trig_ff;
  logic [31:0] sync_ff, endt_ff, result_ff, timer_ff, prbs_ff;
  logic [15:0] transmit_word_ff, status_ff;
  logic [2:0] irq_stat_ff, irq_mask_ff, irq_set;
  logic timer_run_ff, wr_pend_ff, rd_stat_clr;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic rx_en_ff, thresh_ff, tx_en_ff, cw_ff, tx_data_ff, strobe_ff, synth_stop_ff, irq_ff;
  logic tick_a_ff, tick_b_ff, tick_c_ff, tick_rise;
  logic [31:0] rtcv_a_ff, rtcv_b_ff;
  logic [3:0] div_ff;
  logic bit_en;
  logic [5:0] bit_cnt_ff;
  logic [1:0] wmode_ff;

  // ==========================================================
  // bus slave, zero wait states, read data registered in address phase
  logic acc;
  assign acc = hsel && htrans[1] && hready;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    if (a == RTC_OFS_CFG) rd_mux = {24'h000000, cfg_ff};
    else if (a == RTC_OFS_TRIG) rd_mux = {24'h000000, trig_ff};
    else if (a == RTC_OFS_SYNC) rd_mux = sync_ff;
    else if (a == RTC_OFS_TRANSMIT_WORD) rd_mux = {16'h0000, transmit_word_ff};
    else if (a == RTC_OFS_ENDT) rd_mux = endt_ff;
    else if (a == RTC_OFS_STATUS) rd_mux = {11'h000, state_ff, status_ff};
    else if (a == RTC_OFS_RESULT) rd_mux = result_ff;
    else if (a == RTC_OFS_IRQ_STAT) rd_mux = {29'h0000000, irq_stat_ff};
    else if (a == RTC_OFS_IRQ_MASK) rd_mux = {29'h0000000, irq_mask_ff};
    else if (a == RTC_OFS_TIMER) rd_mux = timer_ff;
    else rd_mux = 32'h00000000;
  endfunction

  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= acc && hwrite;
      if (acc) begin
        wr_addr_ff <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata_ff <= (haddr[31:8] == 24'h000000) ? rd_mux(haddr[7:0]) : 32'h00000000;
      end
    end
  end
  assign rd_stat_clr = acc && !hwrite && (haddr[31:8] == 24'h000000)
    && (haddr[7:0] == RTC_OFS_IRQ_STAT);

  logic wr_cmd, wr_abort;
  assign wr_cmd = wr_pend_ff && (wr_addr_ff == RTC_OFS_CMD);
  assign wr_abort = wr_pend_ff && (wr_addr_ff == RTC_OFS_ABORT);

  // parameters other than the interrupt mask are frozen while a command runs
  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      cfg_ff <= 8'h00;
      trig_ff <= 8'h00;
      sync_ff <= 32'h00000000;
      transmit_word_ff <= 16'h0000;
      endt_ff <= 32'h00000000;
      irq_mask_ff <= RTC_IRQ_RST;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == RTC_OFS_IRQ_MASK) irq_mask_ff <= hwdata[2:0];
      else if (state_ff == RTC_S_IDLE) begin
        if (wr_addr_ff == RTC_OFS_CFG) cfg_ff <= hwdata[7:0];
        else if (wr_addr_ff == RTC_OFS_TRIG) trig_ff <= hwdata[7:0];
        else if (wr_addr_ff == RTC_OFS_SYNC) sync_ff <= hwdata;
        else if (wr_addr_ff == RTC_OFS_TRANSMIT_WORD) transmit_word_ff <= hwdata[15:0];
        else if (wr_addr_ff == RTC_OFS_ENDT) endt_ff <= hwdata;
      end
    end
  end

  // ==========================================================
  // clock tick and value synchronisers
  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      tick_a_ff <= 1'b0;
      tick_b_ff <= 1'b0;
      tick_c_ff <= 1'b0;
      rtcv_a_ff <= 32'h00000000;
      rtcv_b_ff <= 32'h00000000;
    end else begin
      tick_a_ff <= rtc_tick;
      tick_b_ff <= tick_a_ff;
      tick_c_ff <= tick_b_ff;
      rtcv_a_ff <= rtc_value;
      rtcv_b_ff <= rtcv_a_ff;
    end
  end
  // value is stable around a tick, so word-wise sampling is safe there
  assign tick_rise = tick_b_ff && !tick_c_ff;

  // ==========================================================
  // end condition
  logic at_end;
  assign at_end = (trig_ff == RTC_TRIG_AT_TIME) && (timer_ff == endt_ff);

  // ==========================================================
  // command sequencer
  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      state_ff <= RTC_S_IDLE;
      status_ff <= RTC_ST_IDLE;
      irq_set <= 3'h0;
      synth_stop_ff <= 1'b0;
      wmode_ff <= RTC_WH_NONE;
    end else begin
      irq_set <= 3'h0;
      synth_stop_ff <= 1'b0;
      case (state_ff)
        RTC_S_IDLE: begin
          if (wr_cmd) begin
            wmode_ff <= cfg_ff[RTC_CFG_WHITEN_LO +: 2];
            if (hwdata[15:0] == RTC_ID_RX_TEST) begin
              state_ff <= RTC_S_RX;
              status_ff <= RTC_ST_ACTIVE;
            end else if (hwdata[15:0] == RTC_ID_TX_TEST) begin
              state_ff <= RTC_S_TX;
              status_ff <= RTC_ST_ACTIVE;
            end else if (hwdata[15:0] == RTC_ID_TSTOP) begin
              state_ff <= RTC_S_TSTOP;
              status_ff <= RTC_ST_ACTIVE;
            end else begin
              status_ff <= RTC_ST_ERR_CMD;
              irq_set[RTC_IRQ_ERR] <= 1'b1;
            end
          end
        end
        RTC_S_RX, RTC_S_TX: begin
          if (wr_abort || at_end) begin
            state_ff <= RTC_S_FINISH;
            status_ff <= wr_abort ? RTC_ST_DONE_ABORT : RTC_ST_DONE_OK;
            synth_stop_ff <= cfg_ff[RTC_CFG_SYNTH_OFF];
          end
        end
        RTC_S_TSTOP: begin
          if (wr_abort) begin
            state_ff <= RTC_S_FINISH;
            status_ff <= RTC_ST_DONE_ABORT;
          end else if (tick_rise) begin
            state_ff <= RTC_S_FINISH;
            status_ff <= RTC_ST_DONE_OK;
          end
        end
        RTC_S_FINISH: begin
          state_ff <= RTC_S_IDLE;
          irq_set[RTC_IRQ_DONE] <= 1'b1;
          irq_set[RTC_IRQ_ABORT] <= (status_ff == RTC_ST_DONE_ABORT);
        end
        default: state_ff <= RTC_S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // radio timer; only the stop path exists, the timer restarts only at reset
  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      timer_ff <= 32'h00000000;
      timer_run_ff <= 1'b1;
      result_ff <= 32'h00000000;
    end else begin
      if (timer_run_ff) timer_ff <= timer_ff + 32'h00000001;
      if (state_ff == RTC_S_TSTOP && !wr_abort && tick_rise) begin
        timer_run_ff <= 1'b0;
        result_ff <= timer_ff - rtcv_b_ff;
      end
    end
  end

  // ==========================================================
  // receiver control
  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      rx_en_ff <= 1'b0;
      thresh_ff <= 1'b0;
    end else begin
      rx_en_ff <= (state_ff == RTC_S_IDLE) ? (wr_cmd && hwdata[15:0] == RTC_ID_RX_TEST)
        : (rx_en_ff && !(wr_abort || at_end));
      thresh_ff <= (state_ff == RTC_S_IDLE)
        ? (wr_cmd && hwdata[15:0] == RTC_ID_RX_TEST && cfg_ff[RTC_CFG_NOSYNC])
        : (thresh_ff && !(wr_abort || at_end));
    end
  end

  // ==========================================================
  // bit rate divider
  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) div_ff <= 4'h0;
    else if (!tx_en_ff || div_ff == 4'(RTC_BIT_DIV - 1)) div_ff <= 4'h0;
    else div_ff <= div_ff + 4'h1;
  end
  assign bit_en = tx_en_ff && (div_ff == 4'(RTC_BIT_DIV - 1));

  // ==========================================================
  // transmitter: preamble, sync, then whitened payload
  logic fb15, fb31, raw_bit, wh_bit, tx_start;
  assign fb15 = prbs_ff[31] ^ prbs_ff[30];
  assign fb31 = prbs_ff[31] ^ prbs_ff[21] ^ prbs_ff[1] ^ prbs_ff[0];
  assign tx_start = (state_ff == RTC_S_IDLE) && wr_cmd && (hwdata[15:0] == RTC_ID_TX_TEST);
  assign raw_bit = transmit_word_ff[4'(RTC_WORD_BITS - 6'h01 - bit_cnt_ff)];

  always_comb begin
    case (wmode_ff)
      RTC_WH_PRBS15: wh_bit = raw_bit ^ fb15;
      RTC_WH_PRBS31: wh_bit = raw_bit ^ fb31;
      RTC_WH_MODE: wh_bit = raw_bit ^ (mode_whiten_en & fb15);
      default: wh_bit = raw_bit;
    endcase
  end

  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      tx_en_ff <= 1'b0;
      cw_ff <= 1'b0;
      phase_ff <= RTC_P_PRE;
      bit_cnt_ff <= 6'h00;
      prbs_ff <= 32'h00000000;
      tx_data_ff <= 1'b0;
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= bit_en && !cw_ff;
      if (tx_start) begin
        tx_en_ff <= 1'b1;
        cw_ff <= cfg_ff[RTC_CFG_CW];
        phase_ff <= RTC_P_PRE;
        bit_cnt_ff <= 6'h00;
        prbs_ff <= (cfg_ff[RTC_CFG_WHITEN_LO +: 2] == RTC_WH_MODE)
          ? mode_whiten_init : RTC_PRBS_SEED;
        tx_data_ff <= 1'b0;
      end else if (tx_en_ff && (wr_abort || at_end)) begin
        tx_en_ff <= 1'b0;
        tx_data_ff <= 1'b0;
      end else if (bit_en && !cw_ff) begin
        case (phase_ff)
          RTC_P_PRE: begin
            tx_data_ff <= RTC_PREAMBLE[5'(6'h1F - bit_cnt_ff)];
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
            if (bit_cnt_ff == RTC_PREAMBLE_BITS - 6'h01) begin
              phase_ff <= RTC_P_SYNC;
              bit_cnt_ff <= 6'h00;
            end
          end
          RTC_P_SYNC: begin
            tx_data_ff <= sync_ff[5'(sync_len_cfg - 6'h01 - bit_cnt_ff)];
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
            if (bit_cnt_ff == sync_len_cfg - 6'h01) begin
              phase_ff <= RTC_P_DATA;
              bit_cnt_ff <= 6'h00;
            end
          end
          default: begin
            tx_data_ff <= wh_bit;
            bit_cnt_ff <= (bit_cnt_ff == RTC_WORD_BITS - 6'h01) ? 6'h00 : bit_cnt_ff + 6'h01;
            if (wmode_ff == RTC_WH_PRBS31) prbs_ff <= {prbs_ff[30:0], fb31};
            else if (wmode_ff != RTC_WH_NONE) prbs_ff <= {prbs_ff[30:17], fb15, 17'h00000};
          end
        endcase
      end
    end
  end

  // ==========================================================
  // interrupts: set wins over read-clear
  always_ff @(posedge clock or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      irq_stat_ff <= RTC_IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (rd_stat_clr ? 3'h0 : irq_stat_ff) | irq_set;
      irq_ff <= |(((rd_stat_clr ? 3'h0 : irq_stat_ff) | irq_set) & irq_mask_ff);
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = rst_ok_n;
  assign hresp = 1'b0;
  assign rx_en = rx_en_ff;
  assign rx_sync_pattern = sync_ff;
  assign sync_thresh_max = thresh_ff;
  assign tx_en = tx_en_ff;
  assign tx_carrier_only = cw_ff;
  assign tx_data = tx_data_ff;
  assign tx_bit_strobe = strobe_ff;
  assign synth_stop = synth_stop_ff;
  assign irq = irq_ff;

  // ==========================================================
  // checks
  property p_rx_start;
    @(posedge clock) disable iff (!rst_ok_n)
    (state_ff == RTC_S_IDLE && wr_cmd && hwdata[15:0] == RTC_ID_RX_TEST)
      |=> rx_en_ff && state_ff == RTC_S_RX;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("rx test did not start");

  property p_sync_prog;
    @(posedge clock) disable iff (!rst_ok_n)
    (rx_en_ff && $past(rx_en_ff)) |-> $stable(rx_sync_pattern);
  endproperty
  a_sync_prog: assert property (p_sync_prog) else $error("sync pattern wrong");

  property p_thresh_restore;
    @(posedge clock) disable iff (!rst_ok_n)
    thresh_ff == (rx_en_ff && cfg_ff[RTC_CFG_NOSYNC]);
  endproperty
  a_thresh_restore: assert property (p_thresh_restore) else $error("threshold wrong");

  property p_synth_off;
    @(posedge clock) disable iff (!rst_ok_n)
    ((state_ff == RTC_S_RX || state_ff == RTC_S_TX) && (wr_abort || at_end))
      |=> synth_stop_ff == cfg_ff[RTC_CFG_SYNTH_OFF] ##1 !synth_stop_ff;
  endproperty
  a_synth_off: assert property (p_synth_off) else $error("synth stop wrong");

  property p_end_time;
    @(posedge clock) disable iff (!rst_ok_n)
    (rx_en_ff && at_end) |=> !rx_en_ff ##1 state_ff == RTC_S_IDLE;
  endproperty
  a_end_time: assert property (p_end_time) else $error("rx did not end");

  property p_tx_start;
    @(posedge clock) disable iff (!rst_ok_n)
    tx_start |=> tx_en_ff && cw_ff == $past(cfg_ff[RTC_CFG_CW]);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx test did not start");

  property p_prbs_seed;
    @(posedge clock) disable iff (!rst_ok_n)
    (tx_start && cfg_ff[RTC_CFG_WHITEN_LO + 1]) |=> prbs_ff == RTC_PRBS_SEED;
  endproperty
  a_prbs_seed: assert property (p_prbs_seed) else $error("prbs seed wrong");

  property p_tx_abort;
    @(posedge clock) disable iff (!rst_ok_n)
    (tx_en_ff && wr_abort) |=> !tx_en_ff ##2 irq_stat_ff[RTC_IRQ_ABORT];
  endproperty
  a_tx_abort: assert property (p_tx_abort) else $error("abort ignored");

  property p_tstop;
    @(posedge clock) disable iff (!rst_ok_n)
    (state_ff == RTC_S_TSTOP && tick_rise && !wr_abort)
      |=> !timer_run_ff && result_ff == $past(timer_ff) - $past(rtcv_b_ff);
  endproperty
  a_tstop: assert property (p_tstop) else $error("timer stop wrong");

  property p_done_irq;
    @(posedge clock) disable iff (!rst_ok_n)
    state_ff == RTC_S_FINISH |=> irq_set[RTC_IRQ_DONE] ##1 irq_stat_ff[RTC_IRQ_DONE];
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done not flagged");

  c_rx_done: cover property (@(posedge clock) disable iff (!rst_ok_n) $fell(rx_en_ff));
  c_tx_data: cover property (@(posedge clock) disable iff (!rst_ok_n)
    tx_en_ff && phase_ff == RTC_P_DATA && bit_en);
  c_tstop: cover property (@(posedge clock) disable iff (!rst_ok_n) $fell(timer_run_ff));
endmodule

// file: core/rtc_pkg.sv
package rtc_pkg;
  // ==========================================================
  // command identifiers
  localparam logic [15:0] RTC_ID_RX_TEST = 16'h0807;
  localparam logic [15:0] RTC_ID_TX_TEST = 16'h0808;
  localparam logic [15:0] RTC_ID_TSTOP = 16'h0809;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] RTC_OFS_CMD = 8'h00;
  localparam logic [7:0] RTC_OFS_CFG = 8'h04;
  localparam logic [7:0] RTC_OFS_TRIG = 8'h08;
  localparam logic [7:0] RTC_OFS_SYNC = 8'h0C;
  localparam logic [7:0] RTC_OFS_TRANSMIT_WORD = 8'h10;
  localparam logic [7:0] RTC_OFS_ENDT = 8'h14;
  localparam logic [7:0] RTC_OFS_ABORT = 8'h18;
  localparam logic [7:0] RTC_OFS_STATUS = 8'h1C;
  localparam logic [7:0] RTC_OFS_RESULT = 8'h20;
  localparam logic [7:0] RTC_OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] RTC_OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] RTC_OFS_TIMER = 8'h2C;
  // ==========================================================
  // configuration byte fields
  localparam int RTC_CFG_CW = 0;
  localparam int RTC_CFG_SYNTH_OFF = 1;
  localparam int RTC_CFG_NOSYNC = 2;
  localparam int RTC_CFG_WHITEN_LO = 2;
  // whitening selector values
  localparam logic [1:0] RTC_WH_NONE = 2'h0;
  localparam logic [1:0] RTC_WH_MODE = 2'h1;
  localparam logic [1:0] RTC_WH_PRBS15 = 2'h2;
  localparam logic [1:0] RTC_WH_PRBS31 = 2'h3;
  localparam logic [31:0] RTC_PRBS_SEED = 32'hAAAA0000;
  // end trigger classifier values
  localparam logic [7:0] RTC_TRIG_AT_TIME = 8'h01;
  // ==========================================================
  // idle, active and end status codes
  localparam logic [15:0] RTC_ST_IDLE = 16'h0000;
  localparam logic [15:0] RTC_ST_ACTIVE = 16'h0001;
  localparam logic [15:0] RTC_ST_DONE_OK = 16'h0400;
  localparam logic [15:0] RTC_ST_DONE_ABORT = 16'h0401;
  localparam logic [15:0] RTC_ST_ERR_CMD = 16'h0800;
  // interrupt status bits
  localparam int RTC_IRQ_DONE = 0;
  localparam int RTC_IRQ_ABORT = 1;
  localparam int RTC_IRQ_ERR = 2;
  localparam logic [2:0] RTC_IRQ_RST = 3'h0;
  // ==========================================================
  // timing and serializer
  localparam int RTC_CLK_HZ = 10000000;
  localparam int RTC_BIT_NS = 1000;
  localparam int RTC_BIT_DIV = RTC_BIT_NS * (RTC_CLK_HZ / 1000000) / 1000;
  localparam logic [5:0] RTC_PREAMBLE_BITS = 6'h20;
  localparam logic [31:0] RTC_PREAMBLE = 32'hAAAAAAAA;
  localparam logic [5:0] RTC_WORD_BITS = 6'h10;
  // ==========================================================
  typedef enum logic [4:0] {
    RTC_S_IDLE = 5'h01,
    RTC_S_RX = 5'h02,
    RTC_S_TX = 5'h04,
    RTC_S_TSTOP = 5'h08,
    RTC_S_FINISH = 5'h10
  } rtc_state_type;
  typedef enum logic [2:0] {
    RTC_P_PRE = 3'h1,
    RTC_P_SYNC = 3'h2,
    RTC_P_DATA = 3'h4
  } rtc_phase_type;
endpackage
